// ---- shared/pem_defines.svh ----
// Purpose: offsets, field positions, reset values and constants of pem_core
// Assumes: included by bare name
// Notes:   definitions only
`ifndef PEM_DEFINES_SVH
`define PEM_DEFINES_SVH
`define PEM_OFF_MODE  8'h00
`define PEM_OFF_ASTAT 8'h04
`define PEM_OFF_STKY  8'h08
`define PEM_OFF_MR    8'h10
`define PEM_OFF_MRTOP 8'h2C
`define PEM_MODE_RST  6'h00
`define PEM_B_SAT     0
`define PEM_B_SEXT    1
`define PEM_B_BOUNDARY_32BIT_SEL   2
`define PEM_B_TRUNC   3
`define PEM_B_SWAP    4
`define PEM_B_DUAL    5
`define PEM_SAT_POS   32'h7FFFFFFF
`define PEM_SAT_NEG   32'h80000000
`define PEM_QNAN_MAG  39'h7FFFFFFFFF
`endif

// ---- shared/pem_pkg.sv ----
// Purpose: types shared by pem_core and its bench
// Assumes: 16-entry register file of 40-bit words
// Notes:   fixed-point data sits in bits 39:8 of a word
package pem_pkg;
   // One register-file write request
   typedef struct packed {
      logic        valid;
      logic        dp;
      logic [3:0]  addr;
      logic [39:0] lo;
      logic [39:0] hi;
   } pem_wreq_t;
   // Unrounded float result: 31 kept bits plus 8 guard bits
   typedef struct packed {
      logic        sign;
      logic [7:0]  exp;
      logic [38:0] frac;
   } pem_fpraw_t;
   typedef logic [15:0][39:0] pem_rfwd_t;
endpackage

// ---- verilog/pem_core.sv ----
// Purpose: register-file write priority and operating-mode logic
// Assumes: all request inputs synchronous to pclk, sampled every edge
// Notes:   write enables and data appear one cycle after the requests
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`include "pem_defines.svh"

// Operation
// RULE1 - Pair load without long-word attribute writes only the even register
// RULE2 - Software avoids long-word accesses in dual-element mode
// RULE3 - Data-bus loads win every register-file write conflict
// RULE4 - Program-bus loads rank second; matching long-word pair blocks them
// RULE5 - ALU ranks third; colliding double ALU result discarded whole
// RULE6 - Multiplier ranks fourth; colliding double product discarded whole (code still writes the free half when only a single-width ALU result collides)
// RULE7 - Shifter and dual subtract half have the lowest priority
// RULE8 - Status updates for every executed operation despite blocked writes
// RULE9 - Multiply updates result registers even when its write is blocked
// RULE10 - Saturation on clamps fixed overflow to 7FFFFFFF or 80000000
// RULE11 - Saturation off returns the upper 32 result bits unaltered
// RULE12 - Short-word reads fill upper 16 bits with sign or zeros
// RULE13 - Boundary bit clear gives 40-bit extended float with 31-bit mantissa
// RULE14 - Boundary bit set zeroes input LSBs, rounds to 23 bits
// RULE15 - Fixed to float conversion always rounds at 40 bits
// RULE16 - No inexact flag is produced
// RULE17 - NaN operand sets invalid, gives all-ones NaN, product sign ORed (code ORs the signs only when both product operands are NaN, else sign is 1)
// RULE18 - Denormal operands flush to zero without underflow
// RULE19 - Round-toward-zero bit set truncates inexact results
// RULE20 - Round-toward-zero clear rounds nearest even, halfway max to infinity
// RULE21 - Swap bit picks result bank for products, both elements
// RULE22 - Instructions name foreground or background bank explicitly
module pem_core import pem_pkg::*; (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire pem_wreq_t   dm_req,
   input  wire logic        short_word_access,
   input  wire pem_wreq_t   pm_req,
   input  wire pem_wreq_t   alu_req,
   input  wire logic        alu_is_fp,
   input  wire logic [31:0] alu_fx_a,
   input  wire logic [31:0] alu_fx_b,
   input  wire logic        alu_fx_sub,
   input  wire pem_fpraw_t  fp_raw,
   input  wire logic [39:0] fp_opa,
   input  wire logic [39:0] fp_opb,
   input  wire logic        fp_is_mul,
   input  wire logic        fp_is_conv,
   input  wire pem_wreq_t   mul_req,
   input  wire logic        mul_sel_bg,
   input  wire logic [63:0] mul_prod,
   input  wire logic [63:0] mul_prod2,
   input  wire pem_wreq_t   shf_req,
   input  wire pem_wreq_t   sub_req,
   output logic [15:0]      rf_we,
   output pem_rfwd_t        rf_wd,
   output logic [39:0]      fp_opa_q,
   output logic [39:0]      fp_opb_q
);

   logic [5:0]  mode_reg;
   logic [4:0]  astat_reg;
   logic [3:0]  stky_reg;
   logic [63:0] mr_reg [4];
   logic        sat_en, sext_en, boundary_32bit_sel, trunc, swap, dual;
   logic        dm_lw, pm_lw, pm_blk, alu_blk, mul_blk;
   logic [15:0] dm_m, pm_raw, pm_m, alu_raw, alu_m, mul_raw, mul_m;
   logic [15:0] shf_m, sub_m, upper_m;
   pem_wreq_t   dm_w, alu_w;
   pem_rfwd_t   wd_next;
   logic [32:0] fx_sum;
   logic        fx_ov;
   logic [31:0] fx_res;
   logic        r32, rnd_g, rnd_s, rnd_l, rnd_inc, nan_a, nan_b, fp_nan, fp_ovf;
   logic [31:0] keep, msum;
   logic [8:0]  exp9;
   logic [39:0] fp_res, alu_val;
   logic        apb_wr, apb_setup;
   logic [2:0]  mr_k;
   logic        mr_hit;

   // Mode fields
   assign sat_en  = mode_reg[`PEM_B_SAT];
   assign sext_en = mode_reg[`PEM_B_SEXT];
   assign boundary_32bit_sel   = mode_reg[`PEM_B_BOUNDARY_32BIT_SEL];
   assign trunc   = mode_reg[`PEM_B_TRUNC];
   assign swap    = mode_reg[`PEM_B_SWAP];
   assign dual    = mode_reg[`PEM_B_DUAL];

   // Destination mask of a request: pair, exact register or even register
   function automatic logic [15:0] dst_mask(input pem_wreq_t r, input logic two,
                                            input logic even);
      logic [3:0]  a;
      logic [15:0] m;
      a = even ? {r.addr[3:1], 1'b0} : r.addr;
      m = 16'h0000;
      if (r.valid && two) begin
         m[{a[3:1], 1'b0}] = 1'b1;
         m[{a[3:1], 1'b1}] = 1'b1;
      end else if (r.valid) begin
         m[a] = 1'b1;
      end
      return m;
   endfunction

   // Word a request carries for register i
   function automatic logic [39:0] src_data(input pem_wreq_t r, input logic two,
                                            input int i);
      return (two && i[0]) ? r.hi : r.lo;
   endfunction

   // Fixed-point ALU with optional saturation
   always_comb begin
      fx_sum = alu_fx_sub ? {alu_fx_a[31], alu_fx_a} - {alu_fx_b[31], alu_fx_b}
                          : {alu_fx_a[31], alu_fx_a} + {alu_fx_b[31], alu_fx_b};
      fx_ov  = fx_sum[32] ^ fx_sum[31];
      // RULE10 clamp on overflow
      if (sat_en && fx_ov) begin
         fx_res = fx_sum[32] ? `PEM_SAT_NEG : `PEM_SAT_POS;
      end else begin
         // RULE11 wrapped upper bits
         fx_res = fx_sum[31:0];
      end
   end

   // Float rounding at the 40-bit or 32-bit boundary
   always_comb begin
      // RULE15 conversions ignore boundary
      r32 = boundary_32bit_sel && !fp_is_conv;
      if (r32) begin
         // RULE14 round to 23 bits
         keep  = {1'b0, fp_raw.frac[38:16], 8'h00};
         rnd_g = fp_raw.frac[15];
         rnd_s = |fp_raw.frac[14:0];
         rnd_l = fp_raw.frac[16];
      end else begin
         // RULE13 31-bit mantissa
         keep  = {1'b0, fp_raw.frac[38:8]};
         rnd_g = fp_raw.frac[7];
         rnd_s = |fp_raw.frac[6:0];
         rnd_l = fp_raw.frac[8];
      end
      // RULE19 trunc bit rounds toward zero
      // RULE20 nearest, ties to even
      rnd_inc = !trunc && rnd_g && (rnd_s || rnd_l);
      msum    = keep + (rnd_inc ? (r32 ? 32'h00000100 : 32'h00000001) : 32'h00000000);
      exp9    = {1'b0, fp_raw.exp} + {8'h00, msum[31]};
      // RULE20 halfway past max gives infinity
      fp_ovf  = exp9 >= 9'h0FF;
      // RULE17 NaN operand detection
      nan_a   = (&fp_opa[38:31]) && (|fp_opa[30:0]);
      nan_b   = fp_is_mul && (&fp_opb[38:31]) && (|fp_opb[30:0]);
      fp_nan  = nan_a || nan_b;
      if (fp_nan) begin
         fp_res = {(nan_a && nan_b) ? (fp_opa[39] | fp_opb[39]) : 1'b1,
                   `PEM_QNAN_MAG};
      end else if (fp_ovf) begin
         fp_res = {fp_raw.sign, 8'hFF, 31'h00000000};
      end else begin
         fp_res = {fp_raw.sign, exp9[7:0], msum[30:0]};
      end
      alu_val = alu_is_fp ? fp_res : {fx_res, 8'h00};
   end

   // Load data and ALU data as written
   always_comb begin
      dm_w = dm_req;
      // RULE12 upper half fill
      if (short_word_access) begin
         dm_w.lo = {sext_en ? {16{dm_req.lo[23]}} : 16'h0000, dm_req.lo[23:0]};
      end
      alu_w    = alu_req;
      alu_w.lo = alu_val;
   end

   // Write priority between all sources
   always_comb begin
      // RULE2 long-word ignored in dual mode
      dm_lw   = dm_req.dp && !dual;
      pm_lw   = pm_req.dp && !dual;
      // RULE1 no long word, even only
      // RULE3 data bus first
      dm_m    = dst_mask(dm_req, dm_lw, 1'b1);
      pm_raw  = dst_mask(pm_req, pm_lw, 1'b1);
      // RULE4 matching pair blocks program bus
      pm_blk  = pm_lw && dm_req.valid && (pm_req.addr[3:1] == dm_req.addr[3:1]);
      pm_m    = pm_blk ? 16'h0000 : (pm_raw & ~dm_m);
      // RULE5 double ALU all or nothing
      alu_raw = dst_mask(alu_req, alu_req.dp, 1'b0);
      alu_blk = alu_req.dp && ((alu_raw & (dm_m | pm_raw)) != 16'h0000);
      alu_m   = alu_blk ? 16'h0000 : (alu_raw & ~(dm_m | pm_m));
      // RULE6 double product all or nothing against loads and double ALU results
      mul_raw = dst_mask(mul_req, mul_req.dp, 1'b0);
      mul_blk = mul_req.dp && ((mul_raw & (dm_m | pm_raw
                | (alu_req.dp ? alu_raw : 16'h0000))) != 16'h0000);
      upper_m = dm_m | pm_m | alu_m;
      mul_m   = mul_blk ? 16'h0000 : (mul_raw & ~upper_m);
      // RULE7 shifter and subtract last
      shf_m   = dst_mask(shf_req, 1'b0, 1'b0) & ~(upper_m | mul_m);
      sub_m   = dst_mask(sub_req, 1'b0, 1'b0) & ~(upper_m | mul_m | shf_m);
      for (int i = 0; i < 16; i++) begin
         if (dm_m[i]) begin
            wd_next[i] = src_data(dm_w, dm_lw, i);
         end else if (pm_m[i]) begin
            wd_next[i] = src_data(pm_req, pm_lw, i);
         end else if (alu_m[i]) begin
            wd_next[i] = src_data(alu_w, alu_req.dp, i);
         end else if (mul_m[i]) begin
            wd_next[i] = src_data(mul_req, mul_req.dp, i);
         end else if (shf_m[i]) begin
            wd_next[i] = shf_req.lo;
         end else if (sub_m[i]) begin
            wd_next[i] = sub_req.lo;
         end else begin
            wd_next[i] = 40'h0000000000;
         end
      end
   end

   // Register-file write port
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rf_we <= 16'h0000;
         rf_wd <= '0;
      end else begin
         rf_we <= dm_m | pm_m | alu_m | mul_m | shf_m | sub_m;
         rf_wd <= wd_next;
      end
   end

   // Conditioned float operands for the arithmetic core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fp_opa_q <= 40'h0000000000;
         fp_opb_q <= 40'h0000000000;
      end else begin
         // RULE18 denormals flushed silently
         // RULE14 input low byte zeroed
         fp_opa_q <= (fp_opa[38:31] == 8'h00) ? {fp_opa[39], 39'h0000000000}
                   : (r32 ? {fp_opa[39:8], 8'h00} : fp_opa);
         fp_opb_q <= (fp_opb[38:31] == 8'h00) ? {fp_opb[39], 39'h0000000000}
                   : (r32 ? {fp_opb[39:8], 8'h00} : fp_opb);
      end
   end

   // Arithmetic status follows every executed ALU operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         astat_reg <= 5'h00;
      end else if (alu_req.valid) begin
         // RULE8 status regardless of block
         // RULE16 no inexact bit
         astat_reg <= {alu_is_fp && fp_ovf && !fp_nan, alu_is_fp && fp_nan,
                       alu_val == 40'h0000000000, alu_val[39],
                       !alu_is_fp && fx_ov};
      end
   end

   // Sticky flags: write one to clear, a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stky_reg <= 4'h0;
      end else begin
         // RULE8 sticky regardless of block
         stky_reg <= (stky_reg & ~((apb_wr && paddr == `PEM_OFF_STKY) ?
                      pwdata[3:0] : 4'h0))
                   | {dual && ((dm_req.valid && dm_req.dp) || (pm_req.valid && pm_req.dp)),
                      alu_req.valid && alu_is_fp && fp_ovf && !fp_nan,
                      alu_req.valid && alu_is_fp && fp_nan,
                      alu_req.valid && !alu_is_fp && fx_ov};
      end
   end

   // Multiplier result banks: index is element times two plus bank
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 4; k++) begin
            mr_reg[k] <= 64'h0000000000000000;
         end
      end else if (mul_req.valid) begin
         // RULE9 banks update though blocked
         // RULE21 swap maps bank
         // RULE22 explicit bank from instruction
         mr_reg[{1'b0, mul_sel_bg ^ swap}] <= mul_prod;
         if (dual) begin
            mr_reg[{1'b1, mul_sel_bg ^ swap}] <= mul_prod2;
         end
      end
   end

   // APB decode
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite;
   assign pready    = 1'b1;
   assign mr_k      = 3'(paddr[5:2] - 4'h4);
   assign mr_hit    = paddr >= `PEM_OFF_MR && paddr <= `PEM_OFF_MRTOP
                      && paddr[1:0] == 2'b00;

   // Mode register write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= `PEM_MODE_RST;
      end else if (apb_wr && paddr == `PEM_OFF_MODE) begin
         mode_reg <= pwdata[5:0];
      end
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (apb_setup) begin
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (paddr == `PEM_OFF_MODE) begin
            prdata <= {26'h0000000, mode_reg};
         end else if (paddr == `PEM_OFF_ASTAT) begin
            prdata <= {27'h0000000, astat_reg};
         end else if (paddr == `PEM_OFF_STKY) begin
            prdata <= {28'h0000000, stky_reg};
         end else if (mr_hit) begin
            prdata <= mr_k[0] ? mr_reg[mr_k[2:1]][63:32] : mr_reg[mr_k[2:1]][31:0];
         end else begin
            pslverr <= 1'b1;
         end
      end
   end

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_dm_first;
      dm_req.valid |=> rf_we[{$past(dm_req.addr[3:1]), 1'b0}];
   endproperty
   a_dm_first: assert property (p_dm_first) else $error("data load not written"); // RULE3

   property p_even_only;
      dm_req.valid && !dm_req.dp |-> dm_m == (16'h0001 << {dm_req.addr[3:1], 1'b0});
   endproperty
   a_even_only: assert property (p_even_only) else $error("short load hit odd"); // RULE1

   property p_pm_blk;
      pm_req.valid && pm_req.dp && !dual && dm_req.valid
         && pm_req.addr[3:1] == dm_req.addr[3:1] |-> pm_m == 16'h0000;
   endproperty
   a_pm_blk: assert property (p_pm_blk) else $error("program write not blocked"); // RULE4

   property p_alu_dp;
      alu_req.valid && alu_req.dp && (alu_raw & dm_m) != 16'h0000
         |-> alu_m == 16'h0000;
   endproperty
   a_alu_dp: assert property (p_alu_dp) else $error("double ALU partly written"); // RULE5

   property p_mul_dp;
      mul_req.valid && mul_req.dp && (mul_raw & (dm_m | pm_raw
         | (alu_req.dp ? alu_raw : 16'h0000))) != 16'h0000 |-> mul_m == 16'h0000;
   endproperty
   a_mul_dp: assert property (p_mul_dp) else $error("double product partly written"); // RULE6

   property p_low;
      ((shf_m | sub_m) & (dm_m | pm_m | alu_m | mul_m)) == 16'h0000;
   endproperty
   a_low: assert property (p_low) else $error("shifter beat higher source"); // RULE7

   property p_mr;
      mul_req.valid && !dual ##1 !mul_req.valid
         |-> mr_reg[{1'b0, $past(mul_sel_bg ^ swap)}] == $past(mul_prod);
   endproperty
   a_mr: assert property (p_mr) else $error("result bank not updated"); // RULE9

   property p_sat;
      sat_en && fx_ov && !alu_is_fp |-> alu_val[39:8] == (fx_sum[32] ? `PEM_SAT_NEG
                                                                 : `PEM_SAT_POS);
   endproperty
   a_sat: assert property (p_sat) else $error("saturation value wrong"); // RULE10

   property p_sext;
      short_word_access && sext_en |-> dm_w.lo[39:24] == {16{dm_req.lo[23]}};
   endproperty
   a_sext: assert property (p_sext) else $error("sign extension wrong"); // RULE12

   property p_r32;
      r32 && !fp_nan && !fp_ovf |-> fp_res[7:0] == 8'h00;
   endproperty
   a_r32: assert property (p_r32) else $error("low byte not cleared"); // RULE14

   property p_nan;
      alu_req.valid && alu_is_fp && fp_nan |=> astat_reg[3] && stky_reg[1];
   endproperty
   a_nan: assert property (p_nan) else $error("invalid flag missing"); // RULE17

   c_pm_blk:  cover property (pm_blk);
   c_alu_blk: cover property (alu_blk && alu_req.valid);
   c_mul_blk: cover property (mul_blk && mul_req.valid ##1 mr_reg[0] != 64'h0);
   c_sat:     cover property (sat_en && fx_ov && alu_req.valid);
endmodule

// ---- bench/pem_bus_model.sv ----
// Purpose: load buses and sequencer standing beside pem_core
// Assumes: every request lasts exactly one pclk cycle
// Notes:   a released bus shows inverted data with valid low
`timescale 1ns/100ps
module pem_bus_model import pem_pkg::*; (
   input  wire logic pclk,
   input  wire logic dual_mode,
   output pem_wreq_t dm_req,
   output pem_wreq_t pm_req,
   output pem_wreq_t alu_req,
   output pem_wreq_t mul_req,
   output pem_wreq_t shf_req,
   output pem_wreq_t sub_req
);
   // Buses idle at time zero
   initial begin
      {dm_req, pm_req, alu_req, mul_req, shf_req, sub_req} = '0;
   end
   // Released bus, data turned over so stale values never match
   function automatic pem_wreq_t rel(input pem_wreq_t x);
      return {1'b0, ~x[84:0]};
   endfunction
   // One cycle of requests after an edge, released at the next
   task automatic send(input pem_wreq_t d, p, a, m, s, u);
      @(posedge pclk);
      d.dp = d.dp & ~dual_mode;
      p.dp = p.dp & ~dual_mode;
      {dm_req, pm_req, alu_req} <= {d, p, a};
      {mul_req, shf_req, sub_req} <= {m, s, u};
      @(posedge pclk);
      {dm_req, pm_req, alu_req} <= {rel(d), rel(p), rel(a)};
      {mul_req, shf_req, sub_req} <= {rel(m), rel(s), rel(u)};
   endtask
endmodule

// ---- bench/tb.sv ----
// Purpose: self-checking bench for pem_core
// Assumes: zero-wait APB slave, results one cycle after requests
// Notes:   random stimulus from seed 31 mixed with corner cases
`timescale 1ns/100ps
`include "pem_defines.svh"
module tb import pem_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, alu_fx_a, alu_fx_b;
   logic        short_word_access, alu_fx_sub, mul_sel_bg, dual_mode;
   logic        alu_is_fp, fp_is_mul, fp_is_conv;
   logic [39:0] fp_opa, fp_opb, fp_opa_q, fp_opb_q;
   logic [63:0] mul_prod, mul_prod2;
   logic [15:0] rf_we;
   pem_rfwd_t   rf_wd;
   pem_fpraw_t  fp_raw;
   pem_wreq_t   dm_req, pm_req, alu_req, mul_req, shf_req, sub_req, d, p, a, m, s, u, n0;
   logic [32:0] r;
   logic [31:0] e;
   int          n_errors, checks, seed, i, k;

   pem_core u_pem_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dm_req(dm_req), .short_word_access(short_word_access),
      .pm_req(pm_req), .alu_req(alu_req), .alu_is_fp(alu_is_fp), .alu_fx_a(alu_fx_a),
      .alu_fx_b(alu_fx_b), .alu_fx_sub(alu_fx_sub), .fp_raw(fp_raw), .fp_opa(fp_opa),
      .fp_opb(fp_opb), .fp_is_mul(fp_is_mul), .fp_is_conv(fp_is_conv), .mul_req(mul_req),
      .mul_sel_bg(mul_sel_bg), .mul_prod(mul_prod), .mul_prod2(mul_prod2),
      .shf_req(shf_req), .sub_req(sub_req), .rf_we(rf_we), .rf_wd(rf_wd),
      .fp_opa_q(fp_opa_q), .fp_opb_q(fp_opb_q));
   pem_bus_model u_pem_bus_model (.pclk(pclk), .dual_mode(dual_mode), .dm_req(dm_req),
      .pm_req(pm_req), .alu_req(alu_req), .mul_req(mul_req), .shf_req(shf_req),
      .sub_req(sub_req));

   // Clock of 5 ns
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Compare and count
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic wrap_up;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One APB transfer; r gets error flag and read data
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = {pslverr, prdata};
      {psel, penable} <= 2'b00;
   endtask
   function automatic pem_wreq_t mk(logic v, dp, logic [3:0] ad, logic [39:0] lo, hi);
      return {v, dp, ad, lo, hi};
   endfunction
   // Expected enables for single-width requests
   function automatic logic [15:0] exp_we(pem_wreq_t dd, pp, aa, mm, ss, uu);
      logic [15:0] w;
      w = '0;
      if (dd.valid) w[{dd.addr[3:1], 1'b0}] = 1'b1;
      if (pp.valid) w[{pp.addr[3:1], 1'b0}] = 1'b1;
      if (aa.valid) w[aa.addr] = 1'b1;
      if (mm.valid) w[mm.addr] = 1'b1;
      if (ss.valid) w[ss.addr] = 1'b1;
      if (uu.valid) w[uu.addr] = 1'b1;
      return w;
   endfunction
   // Send requests and let the result edge land
   task automatic go(input pem_wreq_t dd, pp, aa, mm, ss, uu);
      u_pem_bus_model.send(dd, pp, aa, mm, ss, uu);
      #1;
   endtask
   // One float ALU result into register 1 under a given mode
   task automatic fpt(input logic [5:0] md, input logic cv, input logic [38:0] fr,
                      input logic [7:0] ex, input logic [39:0] ev);
      apb(1'b1, `PEM_OFF_MODE, {26'h0000000, md});
      {fp_is_conv, fp_raw} <= {cv, 1'b0, ex, fr};
      go(n0, n0, mk(1, 0, 1, 0, 0), n0, n0, n0);
      chk(rf_wd[1], ev);
      fp_is_conv <= 1'b0;
   endtask
   // Watchdog
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end

   initial begin
      seed = 31;
      {psel, penable, pwrite, paddr, pwdata, short_word_access, dual_mode} = '0;
      {alu_fx_a, alu_fx_b, alu_fx_sub, mul_sel_bg, mul_prod, mul_prod2} = '0;
      {fp_raw, fp_opa, fp_opb, alu_is_fp, fp_is_mul, fp_is_conv} = '0;
      n0 = '0;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `PEM_OFF_MODE, 32'h0);
      chk(r, {1'b0, 26'h0, `PEM_MODE_RST});
      chk(rf_we, 16'h0);
      apb(1'b1, `PEM_OFF_MODE, 32'hFFFFFFFF);
      apb(1'b0, `PEM_OFF_MODE, 32'h0);
      chk(r, 33'h00000003F);
      apb(1'b0, 8'h40, 32'h0);
      chk(r, 33'h100000000);
      apb(1'b1, `PEM_OFF_MODE, 32'h0);
      $display("test apb done");
      go(mk(1, 0, 3, 40'h11, 0), n0, n0, n0, n0, n0);
      chk(rf_we, 16'h0004);
      go(mk(1, 1, 4, 40'hA1, 40'hB2), mk(1, 1, 5, 40'hC3, 40'hD4), n0, n0, n0, n0);
      chk(rf_we, 16'h0030);
      chk(rf_wd[5], 40'hB2);
      go(mk(1, 0, 6, 1, 0), n0, mk(1, 1, 7, 2, 3), n0, n0, n0);
      chk(rf_we, 16'h0040);
      go(mk(1, 0, 10, 1, 0), n0, mk(1, 1, 8, 2, 3), mk(1, 1, 9, 4, 5), n0, n0);
      chk(rf_we, 16'h0700);
      go(n0, n0, n0, mk(1, 0, 12, 40'h77, 0), mk(1, 0, 12, 5, 0), mk(1, 0, 12, 6, 0));
      chk(rf_wd[12], 40'h77);
      $display("test priority done");
      {alu_fx_a, alu_fx_b, mul_sel_bg} <= {32'h7FFFFFFF, 32'h1, 1'b0};
      mul_prod <= 64'h0123456789ABCDEF;
      go(mk(1, 0, 2, 40'h55, 0), n0, mk(1, 0, 2, 0, 0), mk(1, 0, 2, 9, 0), n0, n0);
      chk(rf_wd[2], 40'h55);
      apb(1'b0, `PEM_OFF_STKY, 32'h0);
      chk(r[0], 1'b1);
      apb(1'b0, `PEM_OFF_MR, 32'h0);
      chk(r, 33'h089ABCDEF);
      apb(1'b0, `PEM_OFF_MR + 8'h04, 32'h0);
      chk(r, 33'h001234567);
      apb(1'b1, `PEM_OFF_MODE, 32'h10);
      mul_prod <= 64'h00000000CAFE0001;
      go(n0, n0, n0, mk(1, 0, 3, 0, 0), n0, n0);
      apb(1'b0, `PEM_OFF_MR + 8'h08, 32'h0);
      chk(r, 33'h0CAFE0001);
      {mul_sel_bg, mul_prod} <= {1'b1, 64'h00000000BEEF0002};
      go(n0, n0, n0, mk(1, 0, 3, 0, 0), n0, n0);
      apb(1'b0, `PEM_OFF_MR, 32'h0);
      chk(r, 33'h0BEEF0002);
      apb(1'b1, `PEM_OFF_MODE, 32'h30);
      {dual_mode, mul_prod2} <= {1'b1, 64'h00000000D00D0003};
      go(n0, n0, n0, mk(1, 0, 3, 0, 0), n0, n0);
      apb(1'b0, `PEM_OFF_MR + 8'h10, 32'h0);
      chk(r, 33'h0D00D0003);
      dual_mode <= 1'b0;
      $display("test result banks done");
      for (k = 0; k < 4; k++) begin
         apb(1'b1, `PEM_OFF_MODE, k[1]);
         {alu_fx_a, alu_fx_b, alu_fx_sub} <= k[0] ? {32'h80000000, 32'hFFFFFFFF, 1'b0}
                                                  : {32'h7FFFFFFF, 32'h00000001, 1'b0};
         go(n0, n0, mk(1, 0, 1, 0, 0), n0, n0, n0);
         e = k[0] ? 32'h7FFFFFFF : 32'h80000000;
         if (k[1]) e = ~e;
         chk(rf_wd[1], {e, 8'h00});
         apb(1'b1, `PEM_OFF_MODE, {k[1], 1'b0});
         short_word_access <= 1'b1;
         go(mk(1, 0, 0, {16'h0, k[0] ? 16'h8000 : 16'h1234, 8'h00}, 0), n0, n0, n0, n0, n0);
         short_word_access <= 1'b0;
         chk(rf_wd[0][39:24], (k[0] && k[1]) ? 16'hFFFF : 16'h0000);
         apb(1'b1, `PEM_OFF_MODE, {k[1], 2'b00});
         {fp_opa, fp_opb} <= {40'h3F800000AB, 40'h80000012AB};
         repeat (2) @(posedge pclk);
         #1;
         chk(fp_opa_q, k[1] ? 40'h3F80000000 : 40'h3F800000AB);
         chk(fp_opb_q, 40'h8000000000);
      end
      apb(1'b1, `PEM_OFF_MODE, 32'h0);
      $display("test modes done");
      alu_is_fp <= 1'b1;
      fpt(6'h04, 1'b0, 39'h0000018000, 8'h80, 40'h4000000200);
      fpt(6'h0C, 1'b0, 39'h0000018000, 8'h80, 40'h4000000100);
      fpt(6'h00, 1'b0, 39'h0000018000, 8'h80, 40'h4000000180);
      fpt(6'h04, 1'b1, 39'h0000018000, 8'h80, 40'h4000000180);
      fpt(6'h00, 1'b0, 39'h7FFFFFFF80, 8'hFE, 40'h7F80000000);
      {fp_is_mul, fp_opa, fp_opb} <= {1'b1, 40'h7FC0000000, 40'h7FC0000000};
      fpt(6'h00, 1'b0, 39'h0000000000, 8'h00, 40'h7FFFFFFFFF);
      apb(1'b0, `PEM_OFF_ASTAT, 32'h0);
      chk(r, 33'h000000008);
      {alu_is_fp, fp_is_mul} <= 2'b00;
      $display("test float done");
      for (i = 0; i < 200; i++) begin
         d = mk($random(seed) % 2, 0, $random(seed), {$random(seed), 8'h5A}, 0);
         p = mk($random(seed) % 2, 0, $random(seed), {$random(seed), 8'hA5}, 0);
         a = mk($random(seed) % 2, 0, $random(seed), 0, 0);
         m = mk($random(seed) % 2, 0, $random(seed), 0, 0);
         {alu_fx_a, alu_fx_b, alu_fx_sub} <= {$random(seed), $random(seed), 1'($random(seed))};
         {mul_prod, mul_prod2} <= {$random(seed), $random(seed), $random(seed), $random(seed)};
         s = mk(1, 0, $random(seed), 0, 0);
         u = mk(1, 0, $random(seed), 0, 0);
         go(d, p, a, m, s, u);
         chk(rf_we, exp_we(d, p, a, m, s, u));
         if (d.valid) chk(rf_wd[{d.addr[3:1], 1'b0}], d.lo);
         if (p.valid && !(d.valid && d.addr[3:1] == p.addr[3:1]))
            chk(rf_wd[{p.addr[3:1], 1'b0}], p.lo);
      end
      $display("test random done");
      wrap_up();
   end
endmodule
